/* File: hw/ckos_key_select.sv */
// Per-pixel color-key source selection and overscan border logic with APB registers.
// Overview of operation
// - Key is AND of four channel terms, disabled terms true, XOR inverted invert bit.
// - Key one selects palette graphics, key zero selects direct color.
// - Each channel term true when value lies in its inclusive 8-bit range.
// - VGA port enable bit picks VGA data for compare, else overlay data.
// - Reset clears four channel enables and sets invert, so palette shows.
// - Overlay compared after read mask, page register fills high bits.
// - Narrow direct colors left-justified with zero low bits before compare.
// - Palette shown when window switch or key is one, else direct color.
// - Control bit six enables overscan, bit seven selects border source.
// - Pin-defined border: color shown when overscan pin high and blank active.
// - Internal border: color shown when blank active and both syncs inactive.
// - Internal blank is VGA blank when VGA port enabled, else system blank.
// - Pedestal: overscan on needs pin high and blank low; off just blank low.
// - Border color comes from three writable red, green, blue registers.
// - Pin sampled video clock fall then return clock rise, or ref rise.
// - Sampled pin goes through the same pipeline delay as blank.
// - VGA port enable disables overlay path and horizontal zoom.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module ckos_key_select
  import ckos_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [6:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pix_en,
  input  wire logic [7:0]  ovl_data,
  input  wire logic [7:0]  vga_data,
  input  wire logic [7:0]  red_in,
  input  wire logic [7:0]  grn_in,
  input  wire logic [7:0]  blu_in,
  input  wire logic        window_switch,
  input  wire logic        int_vsync_n,
  input  wire logic        int_hsync_n,
  input  wire logic        overscan_area,
  input  wire logic        vga_blank_in,
  input  wire logic        sys_blank_in,
  input  wire logic        video_clk,
  input  wire logic        return_clk,
  input  wire logic        ref_a,
  output logic             pix_valid_out,
  output logic             palette_sel,
  output logic             border_active,
  output logic             pedestal_en,
  output logic      [7:0]  border_red,
  output logic      [7:0]  border_grn,
  output logic      [7:0]  border_blu,
  output logic             overlay_path_en,
  output logic             hzoom_en
);

  // ********************************************************************
  // Register file over APB.
  // ********************************************************************
  logic [7:0]  regs_q [NREG];
  logic [7:0]  regs_d [NREG];
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [4:0]  idx;
  logic        mapped;
  logic        vga_en;
  logic        ovs_en;
  logic        src_int;
  logic [4:0]  key_en;
  logic [7:0]  status;

  assign idx     = paddr[6:2];
  assign mapped  = (idx < NREG_IDX) || (idx == IDX_STATUS);
  assign vga_en  = regs_q[IDX_MUX_CTL2][VGA_PORT_EN_BIT];
  assign ovs_en  = regs_q[IDX_GEN_CTRL][OVS_EN_BIT];
  assign src_int = regs_q[IDX_GEN_CTRL][BORDER_SRC_BIT];
  assign key_en  = regs_q[IDX_KEY_CTRL][4:0];
  assign pready  = 1'b1;  // Zero wait states: read data is fetched in the setup cycle.
  assign pslverr = psel && penable && (!mapped || (pwrite && idx == IDX_STATUS));
  assign prdata  = prdata_q;

  // Write on the access phase with lane zero enabled; read data latched at setup.
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
    end
    prdata_d = prdata_q;
    if (psel && penable && pwrite && pstrb[0] && idx < NREG_IDX) begin
      regs_d[idx] = pwdata[7:0];
    end
    if (psel && !penable && !pwrite) begin
      if (idx < NREG_IDX) begin
        prdata_d = {24'h000000, regs_q[idx]};
      end else if (idx == IDX_STATUS) begin
        prdata_d = {24'h000000, status};
      end else begin
        prdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RST[i];
      end
      prdata_q <= 32'h00000000;
    end else begin
      regs_q   <= regs_d;
      prdata_q <= prdata_d;
    end
  end

  // Border color straight from the writable color registers.
  assign border_red = regs_q[IDX_OVS_RED];
  assign border_grn = regs_q[IDX_OVS_GRN];
  assign border_blu = regs_q[IDX_OVS_BLU];
  assign overlay_path_en = !vga_en;
  assign hzoom_en        = !vga_en;

  // ********************************************************************
  // Pin sampler for overscan area and blanks.
  // ********************************************************************
  // Pins and foreign clocks cross two flops; a third stage only feeds edge detection.
  logic [NSMP-1:0] sync1_q;
  logic [NSMP-1:0] sync2_q;
  logic [NSMP-1:0] sync3_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {ref_a, return_clk, video_clk, sys_blank_in, vga_blank_in, overscan_area};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic vck_fall;
  logic rck_rise;
  logic rfa_rise;
  logic ovs_vck_q;
  logic ovs_vck_d;
  logic ovs_smp_q;
  logic ovs_smp_d;
  logic blank_smp_q;
  logic blank_smp_d;

  assign vck_fall = !sync2_q[SMP_VCK] && sync3_q[SMP_VCK];
  assign rck_rise = sync2_q[SMP_RCK] && !sync3_q[SMP_RCK];
  assign rfa_rise = sync2_q[SMP_RFA] && !sync3_q[SMP_RFA];

  // Two-step capture on the system path, one-step on the VGA path.
  // The blank rides with the pin so both see the same sampling.
  always_comb begin
    ovs_vck_d   = ovs_vck_q;
    ovs_smp_d   = ovs_smp_q;
    blank_smp_d = blank_smp_q;
    if (!vga_en) begin
      if (vck_fall) begin
        ovs_vck_d = sync2_q[SMP_OVS];
      end
      if (rck_rise) begin
        ovs_smp_d   = ovs_vck_q;
        blank_smp_d = sync2_q[SMP_SBL];
      end
    end else if (rfa_rise) begin
      ovs_smp_d   = sync2_q[SMP_OVS];
      blank_smp_d = sync2_q[SMP_VBL];
    end
  end

  // Blank resets inactive (high) so no border shows before the first sample.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovs_vck_q   <= 1'b0;
      ovs_smp_q   <= 1'b0;
      blank_smp_q <= 1'b1;
    end else begin
      ovs_vck_q   <= ovs_vck_d;
      ovs_smp_q   <= ovs_smp_d;
      blank_smp_q <= blank_smp_d;
    end
  end

  // ********************************************************************
  // Pixel pipeline: stage one prepares, stage two decides.
  // ********************************************************************
  logic [3:0] ovl_w;
  logic [3:0] col_w;
  logic [2:0] col_sh;
  logic [7:0] low_mask;
  logic [7:0] prep [NCH];
  logic [7:0] s1_q [NCH];
  logic [7:0] s1_d [NCH];
  logic       s1_valid_q;
  logic       s1_win_q;
  logic       s1_ovs_q;
  logic       s1_blank_q;
  logic       s1_vs_q;
  logic       s1_hs_q;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] term;
  logic       key_c;

  assign ovl_w    = ckos_width(regs_q[IDX_FORMAT][FMT_OVL_LSB +: 4]);
  assign col_w    = ckos_width(regs_q[IDX_FORMAT][FMT_COL_LSB +: 4]);
  assign col_sh   = 3'(FULL_W - col_w);
  assign low_mask = 8'hFF >> 3'(FULL_W - ovl_w);

  // Source pick, mask and page fill, left-justify narrow colors.
  always_comb begin
    if (vga_en) begin
      prep[0] = vga_data & regs_q[IDX_RD_MASK];
    end else begin
      prep[0] = (ovl_data & regs_q[IDX_RD_MASK] & low_mask)
              | (regs_q[IDX_PAL_PAGE] & ~low_mask);
    end
    prep[1] = red_in << col_sh;
    prep[2] = grn_in << col_sh;
    prep[3] = blu_in << col_sh;
    for (int c = 0; c < NCH; c++) begin
      s1_d[c] = pix_en ? prep[c] : s1_q[c];
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_cmp
    ckos_range_cmp u_cmp (
      .value    (s1_q[c]),
      .low      (regs_q[IDX_RNG_BASE + 5'(2 * c)]),
      .high     (regs_q[IDX_RNG_BASE + 5'(2 * c + 1)]),
      .in_range (hit[c])
    );
  end

  // Disabled channels are forced true, then invert is applied.
  assign term  = hit | ~key_en[KEY_EN_BLU_BIT:KEY_EN_OVL_BIT];
  assign key_c = (&term) ^ !key_en[KEY_INVERT_BIT];

  logic key_q;
  logic pal_q;
  logic border_q;
  logic ped_q;
  logic valid_q;
  logic key_d;
  logic pal_d;
  logic border_d;
  logic ped_d;
  logic valid_d;

  // Stage two moves only on a pixel enable, giving a fixed two-enable latency.
  always_comb begin
    key_d    = key_q;
    pal_d    = pal_q;
    border_d = border_q;
    ped_d    = ped_q;
    valid_d  = pix_en && s1_valid_q;
    if (pix_en && s1_valid_q) begin
      key_d    = key_c;
      // Window switch ORs with the key.
      pal_d    = key_c || s1_win_q;
      // Border source select; blank is active low.
      if (!ovs_en) begin
        border_d = 1'b0;
      end else if (!src_int) begin
        border_d = s1_ovs_q && !s1_blank_q;
      end else begin
        border_d = !s1_blank_q && s1_vs_q && s1_hs_q;
      end
      ped_d    = ovs_en ? (s1_ovs_q && !s1_blank_q) : !s1_blank_q;
    end
  end

  // Pin and blank enter stage one together with the pixel.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < NCH; c++) begin
        s1_q[c] <= 8'h00;
      end
      s1_valid_q <= 1'b0;
      s1_win_q   <= 1'b0;
      s1_ovs_q   <= 1'b0;
      s1_blank_q <= 1'b1;
      s1_vs_q    <= 1'b1;
      s1_hs_q    <= 1'b1;
      key_q      <= 1'b1;
      pal_q      <= 1'b1;
      border_q   <= 1'b0;
      ped_q      <= 1'b0;
      valid_q    <= 1'b0;
    end else begin
      s1_q <= s1_d;
      if (pix_en) begin
        s1_valid_q <= 1'b1;
        s1_win_q   <= window_switch;
        s1_ovs_q   <= ovs_smp_q;
        s1_blank_q <= blank_smp_q;
        s1_vs_q    <= int_vsync_n;
        s1_hs_q    <= int_hsync_n;
      end
      key_q    <= key_d;
      pal_q    <= pal_d;
      border_q <= border_d;
      ped_q    <= ped_d;
      valid_q  <= valid_d;
    end
  end

  assign pix_valid_out = valid_q;
  assign palette_sel   = pal_q;
  assign border_active = border_q;
  assign pedestal_en   = ped_q;
  assign status        = {4'h0, vga_en, border_q, pal_q, key_q};

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_KEY_DEFAULT: assert property (
    (pix_en && s1_valid_q && key_en[3:0] == 4'h0) |=> key_q == $past(key_en[KEY_INVERT_BIT]))
    else $error("Key with no channel enabled does not follow the invert bit.");

  AST_RED_RANGE: assert property (
    (pix_en && s1_valid_q && key_en[3:0] == 4'h2) |=> key_q == (($past(s1_q[1])
      >= $past(regs_q[5]) && $past(s1_q[1]) <= $past(regs_q[6])) ^ !$past(key_en[4])))
    else $error("Red range compare gives the wrong key.");

  AST_RESET_CTRL: assert property (
    !$past(reset_n) |-> regs_q[IDX_KEY_CTRL] == 8'h10)
    else $error("Key control not at its reset value after reset.");

  AST_SEL_OR: assert property (
    (pix_en && s1_valid_q) |=> palette_sel == ($past(key_c) || $past(s1_win_q)))
    else $error("Palette select is not window OR key.");

  AST_BORDER_PIN: assert property (
    (pix_en && s1_valid_q && ovs_en && !src_int && s1_ovs_q && !s1_blank_q)
      |=> border_active)
    else $error("Pin-defined border missed.");

  AST_BORDER_INT: assert property (
    (pix_en && s1_valid_q && ovs_en && src_int) |=> border_active
      == ($past(!s1_blank_q) && $past(s1_vs_q) && $past(s1_hs_q)))
    else $error("Internal border area wrong.");

  AST_PEDESTAL: assert property (
    (pix_en && s1_valid_q && !ovs_en) |=> pedestal_en == $past(!s1_blank_q))
    else $error("Pedestal does not follow blank with overscan off.");

  AST_VGA_SAMPLE: assert property (
    (vga_en && rfa_rise) |=> blank_smp_q == $past(sync2_q[SMP_VBL]))
    else $error("VGA blank not taken on the reference edge.");

  AST_VIDEO_CLK_FALL: assert property (
    (!vga_en && vck_fall) |=> ovs_vck_q == $past(sync2_q[SMP_OVS]))
    else $error("Overscan pin not captured on the video clock fall.");

  AST_VGA_GATE: assert property (
    vga_en |-> !overlay_path_en && !hzoom_en)
    else $error("Overlay or zoom left on with VGA port enabled.");

  AST_LATENCY: assert property (
    (pix_en && s1_valid_q) |=> pix_valid_out ##1 !pix_valid_out || $past(pix_en))
    else $error("Pixel result not produced one cycle after the enable.");

endmodule : ckos_key_select

/* File: hw/ckos_pkg.sv */
// Package with register map, field positions and reset values of the key and border block.
package ckos_pkg;

  // ********************************************************************
  // Register map: one 8-bit register per 32-bit word, index = addr / 4.
  // ********************************************************************
  localparam int unsigned IDX_W        = 5;
  localparam logic [4:0]  IDX_KEY_CTRL = 5'h00;
  localparam logic [4:0]  IDX_MUX_CTL2 = 5'h01;
  localparam logic [4:0]  IDX_GEN_CTRL = 5'h02;
  localparam logic [4:0]  IDX_RNG_BASE = 5'h03;  // Low/high pairs: overlay, red, green, blue.
  localparam logic [4:0]  IDX_OVS_RED  = 5'h0B;
  localparam logic [4:0]  IDX_OVS_GRN  = 5'h0C;
  localparam logic [4:0]  IDX_OVS_BLU  = 5'h0D;
  localparam logic [4:0]  IDX_RD_MASK  = 5'h0E;
  localparam logic [4:0]  IDX_PAL_PAGE = 5'h0F;
  localparam logic [4:0]  IDX_FORMAT   = 5'h10;
  localparam logic [4:0]  IDX_STATUS   = 5'h11;  // Read only.
  localparam int unsigned NREG         = 17;
  localparam logic [4:0]  NREG_IDX     = 5'h11;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int unsigned KEY_EN_OVL_BIT  = 0;
  localparam int unsigned KEY_EN_RED_BIT  = 1;
  localparam int unsigned KEY_EN_BLU_BIT  = 3;
  localparam int unsigned KEY_INVERT_BIT  = 4;
  localparam int unsigned VGA_PORT_EN_BIT = 7;
  localparam int unsigned OVS_EN_BIT      = 6;
  localparam int unsigned BORDER_SRC_BIT  = 7;
  localparam int unsigned FMT_OVL_LSB     = 0;
  localparam int unsigned FMT_COL_LSB     = 4;
  localparam int unsigned NCH             = 4;   // Overlay/VGA, red, green, blue.
  localparam logic [3:0]  FULL_W          = 4'h8;

  // ********************************************************************
  // Reset values, by register index.
  // ********************************************************************
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h88};

  // Sampler lanes.
  localparam int unsigned SMP_OVS = 0;
  localparam int unsigned SMP_VBL = 1;
  localparam int unsigned SMP_SBL = 2;
  localparam int unsigned SMP_VCK = 3;
  localparam int unsigned SMP_RCK = 4;
  localparam int unsigned SMP_RFA = 5;
  localparam int unsigned NSMP    = 6;

  // Clamp a width field: zero or above eight means a full byte.
  function automatic logic [3:0] ckos_width(input logic [3:0] w);
    ckos_width = (w == 4'h0 || w > FULL_W) ? FULL_W : w;
  endfunction : ckos_width

endpackage : ckos_pkg

/* File: hw/ckos_range_cmp.sv */
// Inclusive 8-bit range comparator for one key channel.
`timescale 1ns/1ps
module ckos_range_cmp (
  input  wire logic [7:0] value,
  input  wire logic [7:0] low,
  input  wire logic [7:0] high,
  output logic            in_range
);

  // A channel matches only when low <= value <= high.
  assign in_range = (value >= low) && (value <= high);

endmodule : ckos_range_cmp

/* File: bench/ckos_fb_model.sv */
// Frame-buffer and graphics controller model for the pixel and pin side.
`timescale 1ns/1ps
module ckos_fb_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        req,
  input  wire logic        slow,
  input  wire logic [42:0] pix_in,
  output logic             pix_en,
  output logic      [42:0] pix_out,
  output logic             video_clk,
  output logic             return_clk,
  output logic             ref_a
);
  logic [4:0] cnt_q;

  // Pixel strobe and data follow the request by one clock.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q   <= 5'h00;
      pix_en  <= 1'b0;
      pix_out <= 43'h0;
    end else begin
      cnt_q   <= (cnt_q >= (slow ? 5'h13 : 5'h09)) ? 5'h00 : cnt_q + 5'h01;
      pix_en  <= req;
      // Idle data lines toggle, so a stale pixel never passes for a fresh one.
      pix_out <= req ? pix_in : ~pix_out;
    end
  end

  // Free-running pin clocks.
  // Video clocks run free; slow mode stretches the period to twenty cycles.
  assign video_clk  = (cnt_q < 5'h05);
  assign return_clk = (cnt_q >= 5'h03) && (cnt_q < 5'h08);
  assign ref_a      = (cnt_q >= 5'h05) && (cnt_q < 5'h0A);
endmodule : ckos_fb_model

/* File: bench/color_key_overscan_select_tb_top.sv */
// Self-checking bench for the color-key and overscan selection block.
`timescale 1ns/1ps
module color_key_overscan_select_tb_top;
  import ckos_pkg::*;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [6:0]  paddr = 7'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready, pslverr, pix_en, window_switch, int_vsync_n, int_hsync_n;
  logic [7:0]  ovl_data, vga_data, red_in, grn_in, blu_in;
  logic [7:0]  border_red, border_grn, border_blu;
  logic        overscan_area = 1'b0;
  logic        vga_blank_in = 1'b1;
  logic        sys_blank_in = 1'b1;
  logic        video_clk, return_clk, ref_a, pix_valid_out, palette_sel;
  logic        border_active, pedestal_en, overlay_path_en, hzoom_en;
  logic        req = 1'b0;
  logic        slow = 1'b0;
  logic [42:0] pix_in = 43'h0;
  logic [42:0] pix_out;
  logic [42:0] p;
  logic [31:0] seed = 32'hC5AA;
  logic [7:0]  regs [NREG];
  logic [7:0]  bnd [4] = '{8'h3F, 8'h40, 8'h80, 8'h81};
  logic [3:0]  exp_q [$];
  logic [3:0]  e_now;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  ckos_key_select i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_en(pix_en), .ovl_data(ovl_data),
    .vga_data(vga_data), .red_in(red_in), .grn_in(grn_in), .blu_in(blu_in),
    .window_switch(window_switch), .int_vsync_n(int_vsync_n), .int_hsync_n(int_hsync_n),
    .overscan_area(overscan_area), .vga_blank_in(vga_blank_in), .sys_blank_in(sys_blank_in),
    .video_clk(video_clk), .return_clk(return_clk), .ref_a(ref_a),
    .pix_valid_out(pix_valid_out), .palette_sel(palette_sel), .border_active(border_active),
    .pedestal_en(pedestal_en), .border_red(border_red), .border_grn(border_grn),
    .border_blu(border_blu), .overlay_path_en(overlay_path_en), .hzoom_en(hzoom_en));

  ckos_fb_model i_fb (.clk(clk), .reset_n(reset_n), .req(req), .slow(slow), .pix_in(pix_in),
    .pix_en(pix_en), .pix_out(pix_out), .video_clk(video_clk), .return_clk(return_clk),
    .ref_a(ref_a));

  // Pixel bundle: window, syncs, overlay, VGA, red, green, blue.
  assign {window_switch, int_vsync_n, int_hsync_n, ovl_data, vga_data} = pix_out[42:24];
  assign {red_in, grn_in, blu_in} = pix_out[23:0];

  // ********************************************************************
  // Tasks and checks
  // ********************************************************************
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++)
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [42:0] rpix();
    logic [31:0] a;
    a = rnd();
    return {a[10:0], rnd()};
  endfunction : rpix

  // Expected {palette, border, pedestal} from the register mirror and pin levels.
  function automatic logic [2:0] expect_of(input logic [42:0] px);
    logic [7:0] ch [4];
    logic [7:0] lm;
    logic [3:0] ow;
    logic [3:0] cw;
    logic       vga;
    logic       k;
    logic       blank;
    logic       ovs_on;
    vga = regs[IDX_MUX_CTL2][VGA_PORT_EN_BIT];
    ow  = regs[IDX_FORMAT][3:0];
    cw  = regs[IDX_FORMAT][7:4];
    if (ow == 4'h0 || ow > 4'h8)
      ow = 4'h8;
    if (cw == 4'h0 || cw > 4'h8)
      cw = 4'h8;
    // Masked overlay sits in the low bits, the page fills the high bits.
    lm    = 8'hFF >> (4'h8 - ow);
    ch[0] = vga ? (px[31:24] & regs[IDX_RD_MASK])
                : ((px[39:32] & regs[IDX_RD_MASK] & lm) | (regs[IDX_PAL_PAGE] & ~lm));
    // Narrow colors move to the top with zero low bits.
    ch[1] = px[23:16] << (4'h8 - cw);
    ch[2] = px[15:8] << (4'h8 - cw);
    ch[3] = px[7:0] << (4'h8 - cw);
    k = 1'b1;
    for (int i = 0; i < NCH; i++)
      if (regs[IDX_KEY_CTRL][i] && (ch[i] < regs[IDX_RNG_BASE + 2 * i]
          || ch[i] > regs[IDX_RNG_BASE + 2 * i + 1]))
        k = 1'b0;
    k = k ^ !regs[IDX_KEY_CTRL][KEY_INVERT_BIT];
    blank = vga ? vga_blank_in : sys_blank_in;
    ovs_on = regs[IDX_GEN_CTRL][OVS_EN_BIT];
    return {k | px[42], ovs_on && !blank
      && (regs[IDX_GEN_CTRL][BORDER_SRC_BIT] ? (px[41] && px[40]) : overscan_area),
      ovs_on ? (overscan_area && !blank) : !blank};
  endfunction : expect_of

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
                     input logic [7:0] ex, input logic exerr);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pslverr", pslverr, exerr);
    if (!wr && !exerr)
      chk("prdata", prdata, {24'h0, ex});
    psel    <= 1'b0;
    penable <= 1'b0;
    if (wr && !exerr)
      regs[idx] = wd;
  endtask : apb

  // Each pixel goes twice; the second copy is only there to push the first out.
  task automatic pix(input logic [42:0] px);
    @(posedge clk);
    req    <= 1'b1;
    pix_in <= px;
    exp_q.push_back({1'b1, expect_of(px)});
    @(posedge clk);
    exp_q.push_back(4'h0);
    @(posedge clk);
    req <= 1'b0;
    for (int n = 0; n < 20 && exp_q.size() > 1; n++)
      @(posedge clk);
    chk("result_wait", exp_q.size() <= 1, 1'b1);
  endtask : pix

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // Result watcher takes the oldest note whenever a result is marked valid.
  always @(posedge clk) begin
    if (pix_valid_out === 1'b1 && exp_q.size() == 0) begin
      chk("result_count", 32'h1, 32'h0);
    end else if (pix_valid_out === 1'b1) begin
      e_now = exp_q.pop_front();
      if (e_now[3]) begin
        chk("palette_sel", palette_sel, e_now[2]);
        chk("border_active", border_active, e_now[1]);
        chk("pedestal_en", pedestal_en, e_now[0]);
      end
    end
  end

  // Hang guard, well above the few thousand cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    for (int i = 0; i < NREG; i++)
      regs[i] = REG_RST[i];
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("overlay_path_en", overlay_path_en, 1'b1);
    for (int i = 0; i < NREG; i++)
      apb(1'b0, 5'(i), 8'h00, REG_RST[i], 1'b0);
    // Status after reset: key and palette select both high.
    apb(1'b0, IDX_STATUS, 8'h00, 8'h03, 1'b0);
    apb(1'b0, 5'h12, 8'h00, 8'h00, 1'b1);
    apb(1'b1, IDX_STATUS, 8'h5A, 8'h00, 1'b1);
    $display("test registers done");
    repeat (4) pix(rpix());
    apb(1'b1, IDX_KEY_CTRL, 8'h00, 8'h00, 1'b0);
    repeat (4) pix(rpix());
    $display("test default done");
    for (int c = 0; c < NCH; c++) begin
      apb(1'b1, IDX_KEY_CTRL, 8'h10 | (8'h01 << c), 8'h00, 1'b0);
      apb(1'b1, 5'(IDX_RNG_BASE + 2 * c), 8'h40, 8'h00, 1'b0);
      apb(1'b1, 5'(IDX_RNG_BASE + 2 * c + 1), 8'h80, 8'h00, 1'b0);
      for (int j = 0; j < 4; j++) begin
        p = rpix();
        p[(c == 0 ? 32 : 24 - 8 * c) +: 8] = bnd[j];
        pix(p);
      end
    end
    $display("test ranges done");
    for (int i = 0; i < 8; i++) begin
      p = rpix();
      apb(1'b1, 5'(IDX_RNG_BASE + i), i[0] ? (p[7:0] | 8'h80) : (p[7:0] & 8'h7F), 8'h00, 1'b0);
    end
    repeat (40) begin
      p = rpix();
      apb(1'b1, IDX_KEY_CTRL, {3'b000, p[42:38]}, 8'h00, 1'b0);
      pix(rpix());
    end
    $display("test random done");
    // Four-bit overlay under a read mask, page in the top bits, tight range.
    apb(1'b1, IDX_FORMAT, 8'h64, 8'h00, 1'b0);
    apb(1'b1, IDX_RD_MASK, 8'hF7, 8'h00, 1'b0);
    apb(1'b1, IDX_PAL_PAGE, 8'hA5, 8'h00, 1'b0);
    apb(1'b1, IDX_RNG_BASE, 8'hA0, 8'h00, 1'b0);
    apb(1'b1, 5'(IDX_RNG_BASE + 1), 8'hA3, 8'h00, 1'b0);
    apb(1'b1, IDX_KEY_CTRL, 8'h11, 8'h00, 1'b0);
    repeat (8) pix(rpix());
    // Six-bit red moved to the top before its compare.
    apb(1'b1, IDX_KEY_CTRL, 8'h12, 8'h00, 1'b0);
    repeat (8) pix(rpix());
    $display("test narrow done");
    // VGA keying kept to one-to-one multiplex.
    apb(1'b1, IDX_MUX_CTL2, 8'h80, 8'h00, 1'b0);
    @(posedge clk);
    chk("overlay_path_en", overlay_path_en, 1'b0);
    chk("hzoom_en", hzoom_en, 1'b0);
    apb(1'b1, IDX_KEY_CTRL, 8'h11, 8'h00, 1'b0);
    repeat (8) pix(rpix());
    $display("test vga done");
    for (int i = 0; i < 3; i++) begin
      p = rpix();
      apb(1'b1, 5'(IDX_OVS_RED + i), p[7:0], 8'h00, 1'b0);
    end
    @(posedge clk);
    chk("border_red", border_red, regs[IDX_OVS_RED]);
    chk("border_grn", border_grn, regs[IDX_OVS_GRN]);
    chk("border_blu", border_blu, regs[IDX_OVS_BLU]);
    // Every overscan mode against pin and blank levels.
    for (int m = 0; m < 32; m++) begin
      apb(1'b1, IDX_MUX_CTL2, {m[4], 7'h00}, 8'h00, 1'b0);
      apb(1'b1, IDX_GEN_CTRL, {m[1:0], 6'h00}, 8'h00, 1'b0);
      slow          <= m[4];
      overscan_area <= m[2];
      vga_blank_in  <= m[3];
      sys_blank_in  <= !m[3];
      repeat (80) @(posedge clk);
      p = rpix();
      p[41:40] = 2'b11;
      pix(p);
      pix(rpix());
    end
    $display("test overscan done");
    conclude();
  end
endmodule : color_key_overscan_select_tb_top
